// ---- hdl/bst_cfg.svh ----
// constants of the boundary-scan test port: instruction codes, widths, capture pattern
// assumes it is included by bare name before the package and the design module
`ifndef BST_CFG_SVH
`define BST_CFG_SVH

`define BST_IR_W        3
`define BST_ID_W        32
`define BST_IR_EXTEST   3'h0
`define BST_IR_IDCODE   3'h1
`define BST_IR_SAMPLEZ  3'h2
`define BST_IR_SAMPLE   3'h4
`define BST_IR_BYPASS   3'h7
`define BST_IR_CAPTURE  3'h1
// identification word; value is arbitrary, bit 0 kept at one as the scan standard asks
`define BST_ID_VALUE    32'h0ABC_DE01
`define BST_BSR_W       16

`endif

// ---- hdl/bst_pkg.sv ----
// types of the boundary-scan test port: controller states
// assumes bst_cfg.svh is compiled first
package bst_pkg;

  typedef enum logic [15:0] {
    ST_TLR  = 16'h0001,
    ST_RTI  = 16'h0002,
    ST_SDS  = 16'h0004,
    ST_CDR  = 16'h0008,
    ST_SHDR = 16'h0010,
    ST_E1DR = 16'h0020,
    ST_PDR  = 16'h0040,
    ST_E2DR = 16'h0080,
    ST_UDR  = 16'h0100,
    ST_SIS  = 16'h0200,
    ST_CIR  = 16'h0400,
    ST_SHIR = 16'h0800,
    ST_E1IR = 16'h1000,
    ST_PIR  = 16'h2000,
    ST_E2IR = 16'h4000,
    ST_UIR  = 16'h8000
  } bst_state_type;

endpackage

// ---- hdl/bst_tap.sv ----
// boundary-scan test access port with its core-side exchange, plus a three-stage synchroniser
// assumes tck, tms, tdi arrive already resolved by the pad pull-ups; clk is the core clock
// What this block does
// [RL1] standard scan port: controller and register selection
// [RL2] reset at power-up, idle until tck runs
// [RL3] floating or tied pins leave memory unaffected
// [RL4] sample on rising tck, launch on falling
// [RL5] tms level steers the controller each edge
// [RL6] undriven tms reads as one
// [RL7] tdi shifts into selected register input end
// [RL8] selection from state and held instruction
// [RL9] undriven tdi shifts in as one
// [RL10] tdo driven only while shifting a register
// [RL11] five tms-high edges reach test-logic-reset
// [RL12] no dedicated test reset input
// [RL13] three-bit instruction preset to identify code
// [RL14] capture-ir loads 01 into low bits
// [RL15] identification word shifts out bit zero first
// [RL16] full sixteen-state transition graph on tms
`timescale 1ns/1ps
`include "bst_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module bst_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // crossing signal
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] a_ff;
  logic [W-1:0] b_ff;
  logic [W-1:0] c_ff;
  logic [W-1:0] q_ff;
  wire          agree = (b_ff == c_ff);

  // a new level counts only once two late stages agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_ff <= '0;
      b_ff <= '0;
      c_ff <= '0;
      q_ff <= '0;
    end else begin
      a_ff <= d;
      b_ff <= a_ff;
      c_ff <= b_ff;
      q_ff <= agree ? c_ff : q_ff;
    end
  end
  assign q = q_ff;
endmodule // bst_sync3

////////////////////////////////////////////////////////////////////////////////
module bst_tap import bst_pkg::*; #(
  parameter int                  BSR_W   = `BST_BSR_W,
  parameter logic [`BST_ID_W-1:0] ID_CODE = `BST_ID_VALUE
) (
  // core clock and power-up reset
  input  wire logic             clk,
  input  wire logic             rst,
  // scan pins
  input  wire logic             tck,
  input  wire logic             tms,
  input  wire logic             tdi,
  output logic                  tdo,
  output logic                  tdo_oe,
  // core side
  input  wire logic [BSR_W-1:0] pin_in,
  output logic      [BSR_W-1:0] drive_word,
  output logic                  drive_en,
  output logic                  out_highz
);

  generate
    if (BSR_W < 2) begin : g_bad_width
      $error("BSR_W must be at least 2");
    end
  endgenerate

  // returns {highz, extest} for an instruction
  function automatic logic [1:0] ir_modes(input logic [`BST_IR_W-1:0] ir);
    ir_modes = {ir == `BST_IR_SAMPLEZ, ir == `BST_IR_EXTEST};
  endfunction

  function automatic bst_state_type next_state(input bst_state_type s, input logic m);
    case (s)
      ST_TLR:  next_state = m ? ST_TLR  : ST_RTI;
      ST_RTI:  next_state = m ? ST_SDS  : ST_RTI;
      ST_SDS:  next_state = m ? ST_SIS  : ST_CDR;
      ST_CDR:  next_state = m ? ST_E1DR : ST_SHDR;
      ST_SHDR: next_state = m ? ST_E1DR : ST_SHDR;
      ST_E1DR: next_state = m ? ST_UDR  : ST_PDR;
      ST_PDR:  next_state = m ? ST_E2DR : ST_PDR;
      ST_E2DR: next_state = m ? ST_UDR  : ST_SHDR;
      ST_UDR:  next_state = m ? ST_SDS  : ST_RTI;
      ST_SIS:  next_state = m ? ST_TLR  : ST_CIR;
      ST_CIR:  next_state = m ? ST_E1IR : ST_SHIR;
      ST_SHIR: next_state = m ? ST_E1IR : ST_SHIR;
      ST_E1IR: next_state = m ? ST_UIR  : ST_PIR;
      ST_PIR:  next_state = m ? ST_E2IR : ST_PIR;
      ST_E2IR: next_state = m ? ST_UIR  : ST_SHIR;
      ST_UIR:  next_state = m ? ST_SDS  : ST_RTI;
      default: next_state = ST_TLR;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // test-clock domain reset: set at once by power-up, released on tck edges
  logic trst_a_ff;
  logic trst_ff;

  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      trst_a_ff <= 1'b1;
      trst_ff   <= 1'b1;
    end else begin
      trst_a_ff <= 1'b0;
      trst_ff   <= trst_a_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // controller and shift registers, rising tck
  bst_state_type          state_ff;
  logic [`BST_IR_W-1:0]   ir_sh_ff;
  logic [`BST_IR_W-1:0]   ir_ff;
  logic [1:0]             mode_ff;
  logic [`BST_ID_W-1:0]   id_sh_ff;
  logic                   byp_ff;
  logic [BSR_W-1:0]       bsr_sh_ff;
  logic [BSR_W-1:0]       bsr_upd_ff;
  logic [BSR_W-1:0]       pin_hold_ff;
  logic                   pin_ack_ff;
  logic                   upd_tgl_ff;
  logic                   tdo_ff;
  logic                   tdo_oe_ff;
  logic                   snap_req_ff;
  logic [BSR_W-1:0]       snap_word_ff;
  logic                   snap_req_q;

  wire in_tlr   = (state_ff == ST_TLR);
  wire in_cdr   = (state_ff == ST_CDR);
  wire in_shdr  = (state_ff == ST_SHDR);
  wire in_udr   = (state_ff == ST_UDR);
  wire in_cir   = (state_ff == ST_CIR);
  wire in_shir  = (state_ff == ST_SHIR);
  wire in_uir   = (state_ff == ST_UIR);
  wire sel_id   = (ir_ff == `BST_IR_IDCODE);                             // RL8
  wire sel_bsr  = (ir_ff == `BST_IR_EXTEST) | (ir_ff == `BST_IR_SAMPLE) |
                  (ir_ff == `BST_IR_SAMPLEZ);                            // RL8
  wire sel_byp  = ~sel_id & ~sel_bsr;                                    // RL8
  wire dr_out   = sel_id ? id_sh_ff[0] : (sel_bsr ? bsr_sh_ff[0] : byp_ff); // RL8 RL15
  wire nxt_tdo  = in_shir ? ir_sh_ff[0] : dr_out;                        // RL10
  wire pin_new  = (snap_req_q != pin_ack_ff);
  wire [`BST_IR_W-1:0] nxt_ir_sh = in_cir  ? `BST_IR_CAPTURE :            // RL14
                                   in_shir ? {tdi, ir_sh_ff[`BST_IR_W-1:1]} : ir_sh_ff; // RL7 RL9

  // tms is the only steering input; an open pin reads one, so the port parks in reset
  always_ff @(posedge tck or posedge trst_ff) begin
    if (trst_ff) begin
      state_ff <= ST_TLR;                                                // RL2 RL12
    end else begin
      state_ff <= next_state(state_ff, tms);                             // RL1 RL4 RL5 RL6 RL11 RL16
    end
  end

  always_ff @(posedge tck or posedge trst_ff) begin
    if (trst_ff) begin
      ir_sh_ff <= `BST_IR_CAPTURE;
    end else begin
      ir_sh_ff <= nxt_ir_sh;
    end
  end

  always_ff @(posedge tck or posedge trst_ff) begin
    if (trst_ff) begin
      id_sh_ff <= '0;
    end else if (in_cdr && sel_id) begin
      id_sh_ff <= ID_CODE;
    end else if (in_shdr && sel_id) begin
      id_sh_ff <= {tdi, id_sh_ff[`BST_ID_W-1:1]};                        // RL7 RL15
    end
  end

  always_ff @(posedge tck or posedge trst_ff) begin
    if (trst_ff) begin
      byp_ff <= 1'b0;
    end else if (in_cdr && sel_byp) begin
      byp_ff <= 1'b0;
    end else if (in_shdr && sel_byp) begin
      byp_ff <= tdi;                                                     // RL7
    end
  end

  always_ff @(posedge tck or posedge trst_ff) begin
    if (trst_ff) begin
      bsr_sh_ff <= '0;
    end else if (in_cdr && sel_bsr) begin
      bsr_sh_ff <= pin_hold_ff;
    end else if (in_shdr && sel_bsr) begin
      bsr_sh_ff <= {tdi, bsr_sh_ff[BSR_W-1:1]};                          // RL7
    end
  end

  // pin snapshot arrives by toggle handshake; the core holds the word until acknowledged
  always_ff @(posedge tck or posedge trst_ff) begin
    if (trst_ff) begin
      pin_hold_ff <= '0;
      pin_ack_ff  <= 1'b0;
    end else if (pin_new) begin
      pin_hold_ff <= snap_word_ff;
      pin_ack_ff  <= snap_req_q;
    end
  end

  bst_sync3 #(.W(1)) u_req_sync (
    .clk (tck),
    .rst (trst_ff),
    .d   (snap_req_ff),
    .q   (snap_req_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // falling tck: instruction and update registers, serial output launch
  always_ff @(negedge tck or posedge trst_ff) begin
    if (trst_ff) begin
      ir_ff   <= `BST_IR_IDCODE;                                         // RL13
      mode_ff <= 2'h0;
    end else if (in_tlr) begin
      ir_ff   <= `BST_IR_IDCODE;                                         // RL13
      mode_ff <= ir_modes(`BST_IR_IDCODE);
    end else if (in_uir) begin
      ir_ff   <= ir_sh_ff;
      mode_ff <= ir_modes(ir_sh_ff);
    end
  end

  always_ff @(negedge tck or posedge trst_ff) begin
    if (trst_ff) begin
      bsr_upd_ff <= '0;
      upd_tgl_ff <= 1'b0;
    end else if (in_udr && sel_bsr) begin
      bsr_upd_ff <= bsr_sh_ff;
      upd_tgl_ff <= ~upd_tgl_ff;
    end
  end

  always_ff @(negedge tck or posedge trst_ff) begin
    if (trst_ff) begin
      tdo_ff    <= 1'b0;
      tdo_oe_ff <= 1'b0;                                                 // RL3
    end else begin
      tdo_ff    <= nxt_tdo;                                              // RL4
      tdo_oe_ff <= in_shdr | in_shir;                                    // RL10
    end
  end

  assign tdo    = tdo_ff;
  assign tdo_oe = tdo_oe_ff;

  //////////////////////////////////////////////////////////////////////////////
  // core clock domain: snapshot source, update sink, mode levels
  logic             ack_q;
  logic             upd_q;
  logic             upd_seen_ff;
  logic [BSR_W-1:0] drive_word_ff;
  logic [1:0]       mode_q;

  wire snap_free = (ack_q == snap_req_ff);
  wire upd_new   = (upd_q != upd_seen_ff);

  bst_sync3 #(.W(1)) u_ack_sync (
    .clk (clk),
    .rst (rst),
    .d   (pin_ack_ff),
    .q   (ack_q)
  );

  bst_sync3 #(.W(1)) u_upd_sync (
    .clk (clk),
    .rst (rst),
    .d   (upd_tgl_ff),
    .q   (upd_q)
  );

  // mode bits change together at one falling edge, so two-bit agreement is safe
  bst_sync3 #(.W(2)) u_mode_sync (
    .clk (clk),
    .rst (rst),
    .d   (mode_ff),
    .q   (mode_q)
  );

  // the word is only reloaded after tck side took the last one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      snap_word_ff <= '0;
      snap_req_ff  <= 1'b0;
    end else if (snap_free) begin
      snap_word_ff <= pin_in;
      snap_req_ff  <= ~snap_req_ff;
    end
  end

  // update word is stable for several tck periods after its toggle, ample for the sync delay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upd_seen_ff   <= 1'b0;
      drive_word_ff <= '0;
    end else if (upd_new) begin
      upd_seen_ff   <= upd_q;
      drive_word_ff <= bsr_upd_ff;
    end
  end

  assign drive_word = drive_word_ff;
  assign drive_en   = mode_q[0];                                         // RL3
  assign out_highz  = mode_q[1];                                         // RL3

endmodule // bst_tap

// ---- tb/bst_tap_assertions.sv ----
// checker for the scan port: tdo enable timing against tms, core mode flags
// assumes it is bound into bst_tap; rst is asynchronous, active high
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module bst_tap_chk (
  // scan pins and reset
  input  wire logic tck,
  input  wire logic rst,
  input  wire logic tms,
  input  wire logic tdo_oe,
  // core side
  input  wire logic clk,
  input  wire logic drive_en,
  input  wire logic out_highz
);
  default clocking @(posedge tck); endclocking
  default disable iff (rst);

  a_five_ones_idle: assert property (tms [*5] |=> !tdo_oe)
    else $error("tdo enabled after five tms ones");
  // shift is entered from capture (tms low) or from exit2 after a pause (tms high, pause entered with tms low)
  a_oe_rise_cause: assert property ($rose(tdo_oe) |-> !$past(tms) && (!$past(tms, 2) || !$past(tms, 3)))
    else $error("tdo enabled without capture and shift steps");
  a_oe_drop_exit: assert property (tdo_oe && tms |=> !tdo_oe)
    else $error("tdo still enabled after leaving shift");
  a_oe_hold_shift: assert property (tdo_oe && !tms |=> tdo_oe)
    else $error("tdo dropped while shifting");
  a_oe_fall_cause: assert property ($fell(tdo_oe) |-> $past(tms))
    else $error("tdo disabled without tms high");
  a_pause_quiet: assert property ($fell(tdo_oe) && !tms |=> !tdo_oe)
    else $error("tdo enabled in pause");
  a_pair_ones_idle: assert property (tms ##1 tms |-> !tdo_oe)
    else $error("tdo enabled after tms high");
  // mode flags live in the core clock domain, so they are watched on clk
  a_modes_excl: assert property (@(posedge clk) !(drive_en && out_highz))
    else $error("drive and high-z flags both set");

  c_shift: cover property ($rose(tdo_oe));
  c_tlr: cover property (tms [*5]);
  c_extest: cover property (@(posedge clk) $rose(drive_en));
  c_highz: cover property (@(posedge clk) $rose(out_highz));
endmodule // bst_tap_chk

bind bst_tap bst_tap_chk u_chk (.tck(tck), .rst(rst), .tms(tms), .tdo_oe(tdo_oe),
  .clk(clk), .drive_en(drive_en), .out_highz(out_highz));

// ---- tb/bst_host.sv ----
// model of the external scan controller: makes tck only inside steps
// assumes tdi is released to its pull-up level between steps
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module bst_host (
  // scan pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // one tck period; tdo taken at the rising edge, as it was launched on the fall
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #6 tck = 1'b1;
    o = tdo;
    #6 tck = 1'b0;
    tdi = 1'b1;
  endtask

  task automatic ones(input int n);
    logic o;
    repeat (n) step(1'b1, 1'b1, o);
  endtask
endmodule // bst_host

// ---- tb/bst_tap_tb_top.sv ----
// testbench for the scan port: id read, ir capture, bypass, boundary modes
// assumes bst_cfg.svh and bst_pkg are compiled first; host owns tck
`timescale 1ns/1ps
`include "bst_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module bst_tap_tb_top;
  logic                  clk;
  logic                  rst;
  logic                  tck;
  logic                  tms;
  logic                  tdi;
  logic                  tdo;
  logic                  tdo_oe;
  logic                  drive_en;
  logic                  out_highz;
  logic [`BST_BSR_W-1:0] pin_in;
  logic [`BST_BSR_W-1:0] drive_word;
  logic [31:0]           q;
  int                    n_errors;
  int                    checks_done;

  bst_tap dut (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .pin_in(pin_in), .drive_word(drive_word), .drive_en(drive_en), .out_highz(out_highz));
  bst_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // from idle: select, capture, shift n bits, update, back to idle
  task automatic scan(input logic is_ir, input logic [31:0] d, input int n, output logic [31:0] r);
    logic o;
    r = 32'h0;
    host.step(1'b1, 1'b1, o);
    if (is_ir) host.step(1'b1, 1'b1, o);
    host.step(1'b0, 1'b1, o);
    host.step(1'b0, 1'b1, o);
    // tdo_oe is launched on the falling tck just given; look once it has settled
    #1;
    chk("oe in shift", 32'(tdo_oe), 32'h1);
    for (int i = 0; i < n; i++) host.step(i == n - 1, d[i], r[i]);
    #1;
    chk("oe after shift", 32'(tdo_oe), 32'h0);
    host.step(1'b1, 1'b1, o);
    host.step(1'b0, 1'b1, o);
  endtask

  task automatic settle;
    repeat (20) @(posedge clk);
  endtask

  task automatic t_reset;
    logic o;
    chk("oe before tck", 32'(tdo_oe), 32'h0);
    chk("word before tck", 32'(drive_word), 32'h0);
    host.ones(7);
    #1;
    chk("oe in reset state", 32'(tdo_oe), 32'h0);
    host.step(1'b0, 1'b1, o);
  endtask

  task automatic t_idcode;
    scan(1'b0, 32'hFFFF_FFFF, 32, q);
    chk("id word", q, `BST_ID_VALUE);
  endtask

  task automatic t_bypass;
    scan(1'b1, 32'h7, 3, q);
    chk("ir capture", q, 32'h1);
    scan(1'b0, 32'h6, 4, q);
    chk("bypass path", q, 32'hC);
  endtask

  task automatic t_boundary;
    logic o;
    scan(1'b1, 32'h4, 3, q);
    scan(1'b0, 32'hA5C3, 16, q);
    chk("pin capture", q, 32'h3C5A);
    settle;
    chk("preload word", 32'(drive_word), 32'hA5C3);
    scan(1'b1, 32'h0, 3, q);
    settle;
    chk("extest flag", 32'(drive_en), 32'h1);
    scan(1'b1, 32'h2, 3, q);
    settle;
    chk("high-z flags", 32'({drive_en, out_highz}), 32'h1);
    host.ones(5);
    settle;
    chk("flags after reset", 32'({drive_en, out_highz}), 32'h0);
    host.step(1'b0, 1'b1, o);
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    pin_in = 16'h3C5A;
    n_errors = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    t_reset;
    t_idcode;
    t_bypass;
    t_boundary;
    t_idcode;
    test_done;
  end

  // scans take a few thousand ns; this is far beyond that
  initial begin
    #200000;
    n_errors++;
    test_done;
  end
endmodule // bst_tap_tb_top
